/* src/compare_a_value_pkg.sv */
// shared constants and types for the compare-a channel
// assumes a 32-bit apb slave and a 16-bit time-base counter on the same clock

package compare_a_value_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int CMP_W = 16;   // compare value width
    localparam int DATA_W = 32;  // apb data width
    localparam int ADDR_W = 8;   // apb address width

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CMP_VALUE = 8'h00;  // compare_a_value
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;    // compare_control
    localparam logic [ADDR_W-1:0] OFS_ACT_A = 8'h08;      // output_a_action_config
    localparam logic [ADDR_W-1:0] OFS_ACT_B = 8'h0c;      // output_b_action_config
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;     // live status

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CTRL_LOAD_LSB = 0;   // load select, 2 bits
    localparam int CTRL_SHDIS_BIT = 4;  // shadow disable
    localparam int CTRL_FULL_BIT = 8;   // shadow full, read only
    localparam int STAT_MATCH_BIT = 0;  // match event level
    localparam int STAT_OUTA_BIT = 1;   // output a level
    localparam int STAT_OUTB_BIT = 2;   // output b level

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [CMP_W-1:0] CMP_RESET = 16'h0000;
    localparam logic SHDIS_RESET = 1'h0;  // shadowed after reset
    localparam logic OUT_RESET = 1'h0;

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    // event that copies shadow into active
    typedef enum logic [1:0] {LOAD_ON_ZERO, LOAD_ON_PERIOD, LOAD_ON_BOTH, LOAD_FROZEN} load_sel_t;
    // response of one output to a match
    typedef enum logic [1:0] {ACT_NONE, ACT_CLEAR, ACT_SET, ACT_TOGGLE} action_t;

endpackage : compare_a_value_pkg

/* src/compare_a_value_aq_if.sv */
// link between compare logic and the action stage
// assumes both ends run on the same clock

`timescale 1ns/100ps

interface compare_a_value_aq_if;
    import compare_a_value_pkg::*;
    logic match;      // compare-a match event
    action_t act_a;   // response of output a
    action_t act_b;   // response of output b
    logic out_a;      // output a level
    logic out_b;      // output b level

    // compare side
    modport source (output match, output act_a, output act_b, input out_a, input out_b);
    // action side
    modport sink (input match, input act_a, input act_b, output out_a, output out_b);
endinterface : compare_a_value_aq_if

/* src/compare_a_value_load_sel.sv */
// picks the shadow load strobe from the time-base events
// assumes zero and period pulses come from logic on the same clock

`timescale 1ns/100ps

module compare_a_value_load_sel (
    // selection
    input wire compare_a_value_pkg::load_sel_t sel_i,
    // time-base events
    input wire logic at_zero_i,
    input wire logic at_period_i,
    // strobe
    output logic strobe_o
);
    import compare_a_value_pkg::*;

    // ----------------------------------------------------------------
    // strobe decode
    // ----------------------------------------------------------------
    // selected load event
    assign strobe_o = (sel_i == LOAD_ON_ZERO) ? at_zero_i :
                      (sel_i == LOAD_ON_PERIOD) ? at_period_i :
                      (sel_i == LOAD_ON_BOTH) ? (at_zero_i | at_period_i) :
                      1'b0;  // frozen: never loads
endmodule : compare_a_value_load_sel

/* src/compare_a_value_action.sv */
// action stage for the compare-a event on both outputs
// assumes the match event is a clean same-clock level

`timescale 1ns/100ps

module compare_a_value_action (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // link
    compare_a_value_aq_if.sink link
);
    import compare_a_value_pkg::*;

    action_t cfg [2];  // per-output response
    logic outs [2];    // per-output level

    assign cfg[0] = link.act_a;
    assign cfg[1] = link.act_b;
    assign link.out_a = outs[0];
    assign link.out_b = outs[1];

    // ----------------------------------------------------------------
    // one qualifier per output
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_out
        always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
                outs[g] <= OUT_RESET;
            end else if (link.match) begin
                case (cfg[g])
                    ACT_CLEAR: outs[g] <= 1'b0;
                    ACT_SET: outs[g] <= 1'b1;
                    ACT_TOGGLE: outs[g] <= ~outs[g];
                    default: outs[g] <= outs[g];  // event ignored
                endcase
            end
        end

        // checks tie each response to the match that caused it
        chk_set_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            link.match && cfg[g] == ACT_SET |=> outs[g])
            else $error("output not high after set action");
        chk_clear_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            link.match && cfg[g] == ACT_CLEAR |=> !outs[g])
            else $error("output not low after clear action");
        chk_toggle_flip: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            link.match && cfg[g] == ACT_TOGGLE |=> outs[g] != $past(outs[g]))
            else $error("output did not invert on toggle");
        chk_idle_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            !link.match || cfg[g] == ACT_NONE |=> $stable(outs[g]))
            else $error("output moved without a qualified match");
    end
endmodule : compare_a_value_action

/* src/compare_a_value_channel.sv */
// compare channel a: apb registers, shadow handling, comparator
// assumes time-base count and zero/period pulses come from the same clock
//
// Contract
// - compare active value to count every cycle
// - match event goes to action stage
// - each output: ignore, low, high, invert
// - shadowed mode is the reset default
// - disable bit 0: accesses reach shadow
// - shadow loads active only on selected event
// - shadow full flag readable by software
// - disable bit 1: accesses reach active
// - active and shadow share one address

`timescale 1ns/100ps

module compare_a_value_channel (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [compare_a_value_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [compare_a_value_pkg::DATA_W-1:0] pwdata_i,
    output logic [compare_a_value_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // time-base
    input wire logic [compare_a_value_pkg::CMP_W-1:0] timebase_count_i,
    input wire logic tb_at_zero_i,
    input wire logic tb_at_period_i,
    // outputs
    output logic compare_a_match_o,
    output logic pwm_out_a_o,
    output logic pwm_out_b_o
);
    import compare_a_value_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [CMP_W-1:0] active_value;  // drives the comparison
    logic [CMP_W-1:0] shadow_value;  // pending value
    logic compare_a_shadow_disable;  // 1: direct access
    load_sel_t compare_a_load_select;  // shadow load event
    logic compare_a_shadow_full;     // shadow holds an unloaded value
    action_t output_a_action_config;
    action_t output_b_action_config;
    logic match_q;                   // registered match level
    logic load_strobe;               // selected load event
    logic ctrl_written;              // helper: control written since reset

    compare_a_value_aq_if link ();

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire access_w = psel_i & penable_i & ~pready_o;     // first access cycle
    wire done_w = psel_i & penable_i & pready_o;        // completing edge
    wire sel_cmp = (paddr_i == OFS_CMP_VALUE);
    wire sel_ctrl = (paddr_i == OFS_CONTROL);
    wire sel_act_a = (paddr_i == OFS_ACT_A);
    wire sel_act_b = (paddr_i == OFS_ACT_B);
    wire sel_stat = (paddr_i == OFS_STATUS);
    wire hit = sel_cmp | sel_ctrl | sel_act_a | sel_act_b | sel_stat;
    wire wr_done = done_w & pwrite_i;
    wire wr_cmp = wr_done & sel_cmp;
    wire wr_ctrl = wr_done & sel_ctrl;
    wire wr_shadow = wr_cmp & ~compare_a_shadow_disable;
    wire wr_direct = wr_cmp & compare_a_shadow_disable;
    wire shadow_load = load_strobe & ~compare_a_shadow_disable;
    wire [CMP_W-1:0] wdata16 = pwdata_i[CMP_W-1:0];

    wire [CMP_W-1:0] cmp_view = compare_a_shadow_disable ? active_value : shadow_value;

    // control word as software sees it
    wire [DATA_W-1:0] ctrl_word = {
        {(DATA_W-CTRL_FULL_BIT-1){1'b0}},
        compare_a_shadow_full,
        {(CTRL_FULL_BIT-CTRL_SHDIS_BIT-1){1'b0}},
        compare_a_shadow_disable,
        {(CTRL_SHDIS_BIT-CTRL_LOAD_LSB-2){1'b0}},
        compare_a_load_select
    };
    wire [DATA_W-1:0] stat_word = {
        {(DATA_W-3){1'b0}}, link.out_b, link.out_a, match_q
    };

    // read multiplexer
    wire [DATA_W-1:0] next_rdata =
        sel_cmp ? {{(DATA_W-CMP_W){1'b0}}, cmp_view} :
        sel_ctrl ? ctrl_word :
        sel_act_a ? {{(DATA_W-2){1'b0}}, output_a_action_config} :
        sel_act_b ? {{(DATA_W-2){1'b0}}, output_b_action_config} :
        sel_stat ? stat_word :
        {DATA_W{1'b0}};

    // ----------------------------------------------------------------
    // apb handshake: one wait state, read data captured with ready
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= {DATA_W{1'b0}};
        end else begin
            pready_o <= access_w;
            pslverr_o <= access_w & ~hit;  // unmapped address
            if (access_w) begin
                prdata_o <= pwrite_i ? {DATA_W{1'b0}} : next_rdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // control and action registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            compare_a_shadow_disable <= SHDIS_RESET;
            compare_a_load_select <= LOAD_ON_ZERO;
            ctrl_written <= 1'b0;
        end else if (wr_ctrl) begin
            compare_a_shadow_disable <= pwdata_i[CTRL_SHDIS_BIT];
            compare_a_load_select <= load_sel_t'(pwdata_i[CTRL_LOAD_LSB +: 2]);
            ctrl_written <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            output_a_action_config <= ACT_NONE;
            output_b_action_config <= ACT_NONE;
        end else if (wr_done & sel_act_a) begin
            output_a_action_config <= action_t'(pwdata_i[1:0]);
        end else if (wr_done & sel_act_b) begin
            output_b_action_config <= action_t'(pwdata_i[1:0]);
        end
    end

    // ----------------------------------------------------------------
    // shadow and active compare value
    // ----------------------------------------------------------------
    compare_a_value_load_sel u_load_sel (
        .sel_i(compare_a_load_select),
        .at_zero_i(tb_at_zero_i),
        .at_period_i(tb_at_period_i),
        .strobe_o(load_strobe)
    );

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shadow_value <= CMP_RESET;
        end else if (wr_shadow) begin
            shadow_value <= wdata16;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            active_value <= CMP_RESET;
        end else if (wr_direct) begin
            active_value <= wdata16;
        end else if (shadow_load) begin
            active_value <= shadow_value;
        end
    end

    // set wins over the load clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            compare_a_shadow_full <= 1'b0;
        end else if (wr_shadow) begin
            compare_a_shadow_full <= 1'b1;
        end else if (shadow_load) begin
            compare_a_shadow_full <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // comparator and action stage
    // ----------------------------------------------------------------
    // equality every cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= (active_value == timebase_count_i);
        end
    end

    assign link.match = match_q;
    assign link.act_a = output_a_action_config;
    assign link.act_b = output_b_action_config;

    compare_a_value_action u_action (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .link(link.sink)
    );

    assign compare_a_match_o = match_q;
    assign pwm_out_a_o = link.out_a;
    assign pwm_out_b_o = link.out_b;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    chk_match_equal: assert property (
        active_value == timebase_count_i |=> compare_a_match_o)
        else $error("equal values gave no match");
    chk_match_cause: assert property (
        compare_a_match_o |-> $past(active_value) == $past(timebase_count_i))
        else $error("match without equal values");
    chk_reset_shadowed: assert property (
        !ctrl_written |-> !compare_a_shadow_disable)
        else $error("shadow disabled without a control write");
    chk_shadow_write: assert property (
        wr_shadow && !shadow_load |=> shadow_value == $past(wdata16)
            && $stable(active_value))
        else $error("shadowed write did not reach shadow only");
    chk_load_copy: assert property (
        shadow_load |=> active_value == $past(shadow_value))
        else $error("load event did not copy shadow");
    chk_no_load: assert property (
        !compare_a_shadow_disable && !shadow_load |=> $stable(active_value))
        else $error("active changed without a load event");
    chk_full_set: assert property (
        wr_shadow |=> compare_a_shadow_full ##0 ctrl_word[CTRL_FULL_BIT])
        else $error("full flag not set after shadow write");
    chk_full_clear: assert property (
        shadow_load && !wr_shadow |=> !compare_a_shadow_full)
        else $error("full flag not cleared by load");
    chk_direct_write: assert property (
        wr_direct |=> active_value == $past(wdata16) && $stable(shadow_value))
        else $error("direct write did not reach active only");
    chk_shared_read: assert property (
        access_w && sel_cmp && !pwrite_i |=> pready_o
            && prdata_o[CMP_W-1:0] == $past(cmp_view))
        else $error("read of shared address returned wrong copy");

    cov_shadow_load: cover property (wr_shadow ##[1:50] shadow_load);
    cov_direct_write: cover property (wr_direct);
    cov_match_seen: cover property ($rose(compare_a_match_o));
    cov_full_write: cover property (compare_a_shadow_full && wr_shadow);

endmodule : compare_a_value_channel

/* tb/tbase_model.sv */
// time-base counter model feeding the compare channel
// assumes one clock shared with the channel; the count holds while stopped
`timescale 1ns/100ps
module tbase_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // control from the bench
    input wire logic run_i,
    input wire logic [compare_a_value_pkg::CMP_W-1:0] period_i,
    // time-base outputs
    output logic [compare_a_value_pkg::CMP_W-1:0] count_o,
    output logic at_zero_o,
    output logic at_period_o
);
    import compare_a_value_pkg::*;
    logic [CMP_W-1:0] next_count; // count after this edge
    // wrap to zero after the period value
    assign next_count = (count_o == period_i) ? 16'h0000 : count_o + 16'h0001;
    // count up; event pulses last one cycle and only while running
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= 16'h0000;
            at_zero_o <= 1'b0;
            at_period_o <= 1'b0;
        end else if (run_i) begin
            count_o <= next_count;
            at_zero_o <= (next_count == 16'h0000);
            at_period_o <= (next_count == period_i);
        end else begin
            at_zero_o <= 1'b0;
            at_period_o <= 1'b0;
        end
    end
endmodule : tbase_model

/* tb/tb_compare_a_value_channel.sv */
// self-checking bench for the compare-a channel
// assumes the package, the channel and the time-base model are compiled first
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module tb_pwm_compare_a_shadowed;
    import compare_a_value_pkg::*;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h00000000;
    logic [DATA_W-1:0] prdata_o;
    logic pready_o, pslverr_o, compare_a_match_o, pwm_out_a_o, pwm_out_b_o;
    logic run = 1'b0; // time-base runs while high
    logic [CMP_W-1:0] timebase_count;
    logic at_zero, at_period;
    int err_total = 0;
    int comparisons = 0;
    // ----------------------------------------------------------------
    // clock, design and partner
    // ----------------------------------------------------------------
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    compare_a_value_channel compare_a_value_channel_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .timebase_count_i(timebase_count), .tb_at_zero_i(at_zero),
        .tb_at_period_i(at_period), .compare_a_match_o(compare_a_match_o),
        .pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o));
    // period 11 keeps every stop point clear of the zero and period events
    tbase_model tbase_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run),
        .period_i(16'h000b), .count_o(timebase_count), .at_zero_o(at_zero),
        .at_period_o(at_period));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] rd, output logic er);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            err_total++;
            $display("ERROR apb ready expected 1 seen 0");
            tally_and_finish();
        end
    endtask : apb
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask : wr
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        logic [DATA_W-1:0] rd;
        logic er;
        apb(1'b0, a, 32'h00000000, rd, er);
        `CHK("read data", ex, rd)
    endtask : rd_chk
    // run the time-base to the next rising match, check the count that matched, stop
    task automatic wait_match(input logic [CMP_W-1:0] ex);
        logic pm;
        logic [CMP_W-1:0] cp;
        int n;
        pm = 1'b1;
        cp = 16'hffff;
        run <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk_sys_i);
            if (compare_a_match_o === 1'b1 && pm === 1'b0) break;
            pm = compare_a_match_o;
            cp = timebase_count;
        end
        run <= 1'b0;
        if (n == 40) begin
            err_total++;
            $display("ERROR match wait expected rise seen none");
            tally_and_finish();
        end
        `CHK("match count", ex, cp)
    endtask : wait_match
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(OFS_CONTROL, 32'h00000000);
        rd_chk(OFS_CMP_VALUE, 32'h00000000);
    endtask : t_reset
    // shadowed write waits for the period event
    task automatic t_period();
        wr(OFS_CONTROL, 32'h00000001);
        wr(OFS_CMP_VALUE, 32'h00000007);
        rd_chk(OFS_CONTROL, 32'h00000101);
        rd_chk(OFS_CMP_VALUE, 32'h00000007);
        rd_chk(OFS_STATUS, 32'h00000001);
        wait_match(16'h0007);
        rd_chk(OFS_CONTROL, 32'h00000001);
    endtask : t_period
    // frozen select keeps the old active value through zero and period
    task automatic t_frozen();
        wr(OFS_CONTROL, 32'h00000003);
        wr(OFS_CMP_VALUE, 32'h00000002);
        wait_match(16'h0007);
        rd_chk(OFS_CONTROL, 32'h00000103);
        wr(OFS_CONTROL, 32'h00000000);
        wait_match(16'h0002);
        wr(OFS_CONTROL, 32'h00000002);
        wr(OFS_CMP_VALUE, 32'h00000004);
        wait_match(16'h0004);
    endtask : t_frozen
    // direct mode reaches the active value, shadow kept behind the same address
    task automatic t_direct();
        wr(OFS_CONTROL, 32'h00000013);
        wr(OFS_CMP_VALUE, 32'h00000005);
        rd_chk(OFS_CMP_VALUE, 32'h00000005);
        rd_chk(OFS_CONTROL, 32'h00000013);
        wait_match(16'h0005);
        wr(OFS_CONTROL, 32'h00000003);
        rd_chk(OFS_CMP_VALUE, 32'h00000004);
        wait_match(16'h0005);
    endtask : t_direct
    // every action code on output a, the reverse code on output b
    task automatic t_actions();
        logic a0, b0;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_ACT_A, k);
            wr(OFS_ACT_B, 3 - k);
            wait_match(16'h0005);
            a0 = pwm_out_a_o;
            b0 = pwm_out_b_o;
            @(posedge clk_sys_i);
            `CHK("output a", act_f(action_t'(k), a0), pwm_out_a_o)
            `CHK("output b", act_f(action_t'(3 - k), b0), pwm_out_b_o)
        end
    endtask : t_actions
    function automatic logic act_f(input action_t a, input logic o);
        case (a)
            ACT_CLEAR: return 1'b0;
            ACT_SET: return 1'b1;
            ACT_TOGGLE: return ~o;
            default: return o;
        endcase
    endfunction : act_f
    // unmapped address answers with error and zero data
    task automatic t_unmapped();
        logic [DATA_W-1:0] rd;
        logic er;
        apb(1'b0, 8'h20, 32'h00000000, rd, er);
        `CHK("unmapped error", 1'b1, er)
        `CHK("unmapped data", 32'h00000000, rd)
    endtask : t_unmapped
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_period();
        t_frozen();
        t_direct();
        t_actions();
        t_unmapped();
        tally_and_finish();
    end
endmodule : tb_pwm_compare_a_shadowed
